// ---- spfm_pkg.sv ----
// Constants and carrier types for the shared pin function selector
// ============================================================
// How it works
// - Among enabled functions sharing a pin, only the highest one drives it.
// - Of 30 pins one is output-only for the port function, one input-only, the rest two-way.
// - First enabling an alternate may hand that module a spurious edge.
// - A lower function losing its pin may see a spurious edge.
// - Timer clock pin, when the second alternate owns it, feeds both timer modules and the modulo timer.
// ============================================================
package spfm_pkg;

    // Pin count and the two one-way pins
    localparam int NUM_PINS = 30;
    localparam int PIN_IN_ONLY = 5;
    localparam int PIN_OUT_ONLY = 4;

    // On the input-only pin the second alternate is the timer clock
    localparam int TIMER_CLK_PIN = PIN_IN_ONLY;

    // Reset values of the pad side and of the routed inputs
    localparam logic [NUM_PINS-1:0] RST_PAD_OUT = 30'h0000_0000;
    localparam logic [NUM_PINS-1:0] RST_PAD_OE = 30'h0000_0000;
    localparam logic [NUM_PINS-1:0] RST_FN_IN = 30'h0000_0000;
    localparam logic [NUM_PINS-1:0] RST_SYNC = 30'h0000_0000;
    localparam logic RST_EXT_CLK = 1'b0;

    // Which pins may ever be driven, and which the port function may sense
    localparam logic [NUM_PINS-1:0] OUT_CAPABLE = ~(30'h0000_0001 << PIN_IN_ONLY);
    localparam logic [NUM_PINS-1:0] IN_CAPABLE = ~(30'h0000_0001 << PIN_OUT_ONLY);

    typedef enum logic [1:0] {
        OWN_PORT,
        OWN_ALT1,
        OWN_ALT2,
        OWN_ALT3
    } spfm_owner_t;

    // Drive request of the port function, one bit per pin
    typedef struct packed {
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
    } spfm_drive_t;

    // Enable plus drive request of one alternate function, one bit per pin
    typedef struct packed {
        logic [NUM_PINS-1:0] en;
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
    } spfm_fn_t;

    // Sensed pin values as seen by each function
    typedef struct packed {
        logic [NUM_PINS-1:0] port;
        logic [NUM_PINS-1:0] alt1;
        logic [NUM_PINS-1:0] alt2;
        logic [NUM_PINS-1:0] alt3;
    } spfm_sense_t;

endpackage

// ---- spfm_top.sv ----
// Per-pin function selector between the port and three alternates
`timescale 1ns/1ps
module spfm_top
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Function requests from port logic and peripherals
    input wire spfm_pkg::spfm_drive_t port_req,
    input wire spfm_pkg::spfm_fn_t alt1_req,
    input wire spfm_pkg::spfm_fn_t alt2_req,
    input wire spfm_pkg::spfm_fn_t alt3_req,
    // Pad side
    input wire logic [spfm_pkg::NUM_PINS-1:0] pad_in,
    output logic [spfm_pkg::NUM_PINS-1:0] pad_out,
    output logic [spfm_pkg::NUM_PINS-1:0] pad_oe,
    // Sensed values per function
    output spfm_pkg::spfm_sense_t fn_in,
    // External timer clock to the timers
    output logic timer_pwm_module_a_ext_clk,
    output logic timer_pwm_module_b_ext_clk,
    output logic sixteen_bit_modulo_timer_ext_clk
);

    localparam int N = spfm_pkg::NUM_PINS;

    spfm_pkg::spfm_owner_t owner [N];
    logic [N-1:0] sel_out;
    logic [N-1:0] sel_oe;
    logic [N-1:0] pad_out_q;
    logic [N-1:0] pad_oe_q;
    logic [N-1:0] sync1_q;
    logic [N-1:0] sync2_q;
    spfm_pkg::spfm_sense_t fn_in_q;
    spfm_pkg::spfm_sense_t fn_in_d;
    logic ext_clk_sel;
    logic ext_clk_a_q;
    logic ext_clk_b_q;
    logic ext_clk_m_q;

    // ============================================================
    // Ownership per pin
    // ============================================================
    for (genvar i = 0; i < N; i++)
    begin : g_pin
        always_comb
        begin
            if (alt3_req.en[i])
            begin
                owner[i] = spfm_pkg::OWN_ALT3;
            end
            else if (alt2_req.en[i])
            begin
                owner[i] = spfm_pkg::OWN_ALT2;
            end
            else if (alt1_req.en[i])
            begin
                owner[i] = spfm_pkg::OWN_ALT1;
            end
            else
            begin
                owner[i] = spfm_pkg::OWN_PORT;
            end
        end

        always_comb
        begin
            case (owner[i])
                spfm_pkg::OWN_ALT3:
                begin
                    sel_out[i] = alt3_req.out[i];
                    sel_oe[i] = alt3_req.oe[i];
                end
                spfm_pkg::OWN_ALT2:
                begin
                    sel_out[i] = alt2_req.out[i];
                    sel_oe[i] = alt2_req.oe[i];
                end
                spfm_pkg::OWN_ALT1:
                begin
                    sel_out[i] = alt1_req.out[i];
                    sel_oe[i] = alt1_req.oe[i];
                end
                default:
                begin
                    sel_out[i] = port_req.out[i];
                    // Output-only pin is always driven by its port function
                    sel_oe[i] = (i == spfm_pkg::PIN_OUT_ONLY) ? 1'b1 : port_req.oe[i];
                end
            endcase
        end

        // Only the owner sees the pin; others read low, so a switch of owner
        // can hand either module a single spurious edge
        always_comb
        begin
            fn_in_d.port[i] = sync2_q[i] & spfm_pkg::IN_CAPABLE[i]
                & (owner[i] == spfm_pkg::OWN_PORT);
            fn_in_d.alt1[i] = sync2_q[i] & (owner[i] == spfm_pkg::OWN_ALT1);
            fn_in_d.alt2[i] = sync2_q[i] & (owner[i] == spfm_pkg::OWN_ALT2);
            fn_in_d.alt3[i] = sync2_q[i] & (owner[i] == spfm_pkg::OWN_ALT3);
        end
    end

    // ============================================================
    // Pad drive
    // ============================================================
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pad_out_q <= spfm_pkg::RST_PAD_OUT;
            pad_oe_q <= spfm_pkg::RST_PAD_OE;
        end
        else
        begin
            pad_out_q <= sel_out;
            pad_oe_q <= sel_oe & spfm_pkg::OUT_CAPABLE;
        end
    end

    // ============================================================
    // Pad input synchroniser and routing
    // ============================================================
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sync1_q <= spfm_pkg::RST_SYNC;
            sync2_q <= spfm_pkg::RST_SYNC;
        end
        else
        begin
            sync1_q <= pad_in;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            fn_in_q <= {spfm_pkg::RST_FN_IN, spfm_pkg::RST_FN_IN,
                        spfm_pkg::RST_FN_IN, spfm_pkg::RST_FN_IN};
        end
        else
        begin
            fn_in_q <= fn_in_d;
        end
    end

    // ============================================================
    // External timer clock fan-out
    // ============================================================
    assign ext_clk_sel = (owner[spfm_pkg::TIMER_CLK_PIN] == spfm_pkg::OWN_ALT2);

    // Three copies so each timer input comes from its own flop
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ext_clk_a_q <= spfm_pkg::RST_EXT_CLK;
            ext_clk_b_q <= spfm_pkg::RST_EXT_CLK;
            ext_clk_m_q <= spfm_pkg::RST_EXT_CLK;
        end
        else
        begin
            ext_clk_a_q <= ext_clk_sel & sync2_q[spfm_pkg::TIMER_CLK_PIN];
            ext_clk_b_q <= ext_clk_sel & sync2_q[spfm_pkg::TIMER_CLK_PIN];
            ext_clk_m_q <= ext_clk_sel & sync2_q[spfm_pkg::TIMER_CLK_PIN];
        end
    end

    assign pad_out = pad_out_q;
    assign pad_oe = pad_oe_q;
    assign fn_in = fn_in_q;
    assign timer_pwm_module_a_ext_clk = ext_clk_a_q;
    assign timer_pwm_module_b_ext_clk = ext_clk_b_q;
    assign sixteen_bit_modulo_timer_ext_clk = ext_clk_m_q;

    // ============================================================
    // Assertions
    // ============================================================
    for (genvar k = 0; k < N; k++)
    begin : g_chk
        a_top_wins_pin: assert property (
            @(posedge ref_clk) disable iff (!rst_n)
            $past(rst_n) && $past(alt3_req.en[k]) |->
                pad_out_q[k] == $past(alt3_req.out[k]))
            else $error("highest enabled function does not drive the pin");

        a_second_beats_first: assert property (
            @(posedge ref_clk) disable iff (!rst_n)
            $past(rst_n) && $past(alt2_req.en[k]) && !$past(alt3_req.en[k]) |->
                pad_out_q[k] == $past(alt2_req.out[k]))
            else $error("second alternate lost to a lower function");

        a_alt1_owned_input: assert property (
            @(posedge ref_clk) disable iff (!rst_n)
            fn_in_q.alt1[k] |-> $past(alt1_req.en[k]) && !$past(alt2_req.en[k])
                && !$past(alt3_req.en[k]) && $past(sync2_q[k]))
            else $error("first alternate sensed a pin it did not own");

        a_port_loses_input: assert property (
            @(posedge ref_clk) disable iff (!rst_n)
            $past(rst_n) && ($past(alt1_req.en[k]) || $past(alt2_req.en[k])
                || $past(alt3_req.en[k])) |->
                !fn_in_q.port[k])
            else $error("port still sees pin after losing it");
    end

    a_in_only_never_driven: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !pad_oe_q[spfm_pkg::PIN_IN_ONLY] && !fn_in_q.port[spfm_pkg::PIN_OUT_ONLY])
        else $error("one-way pin used in the wrong direction");

    a_out_only_driven: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n) && !$past(alt1_req.en[spfm_pkg::PIN_OUT_ONLY])
            && !$past(alt2_req.en[spfm_pkg::PIN_OUT_ONLY])
            && !$past(alt3_req.en[spfm_pkg::PIN_OUT_ONLY]) |->
            pad_oe_q[spfm_pkg::PIN_OUT_ONLY])
        else $error("output-only pin not driven by its port");

    a_ext_clk_fanout: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n) |-> ext_clk_a_q == ext_clk_b_q && ext_clk_b_q == ext_clk_m_q
            && ext_clk_a_q == ($past(ext_clk_sel)
            && $past(sync2_q[spfm_pkg::TIMER_CLK_PIN])))
        else $error("timer clock not fanned out to all three timers");

    a_ext_clk_gated: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(alt3_req.en[spfm_pkg::TIMER_CLK_PIN]) |-> !ext_clk_m_q)
        else $error("timer clock passed while reset input owns pin");

endmodule

// ---- spfm_pad_model.sv ----
// Pad model: resolves each pin from the device drive and the board level
`timescale 1ns/1ps
module spfm_pad_model
(
    // Device drive
    input wire logic [spfm_pkg::NUM_PINS-1:0] pad_out,
    input wire logic [spfm_pkg::NUM_PINS-1:0] pad_oe,
    // Board level on undriven pins
    input wire logic [spfm_pkg::NUM_PINS-1:0] ext_level,
    // Level seen by the device
    output logic [spfm_pkg::NUM_PINS-1:0] pad_in
);
    // ============================================================
    // Pin resolution
    // Board level only where the device has let go, so a stale drive never leaks
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

// ---- spfm_top_tb.sv ----
// Self-checking bench for the shared pin function selector
`timescale 1ns/1ps
module spfm_top_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    spfm_pkg::spfm_drive_t port_req = '0;
    spfm_pkg::spfm_fn_t alt1_req = '0;
    spfm_pkg::spfm_fn_t alt2_req = '0;
    spfm_pkg::spfm_fn_t alt3_req = '0;
    logic [29:0] ext_level = 30'h0000_0000;
    logic [29:0] pad_in, pad_out, pad_oe;
    spfm_pkg::spfm_sense_t fn_in;
    logic clk_a, clk_b, clk_m;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    // ============================================================
    // Instances
    spfm_top spfm_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .port_req(port_req),
        .alt1_req(alt1_req), .alt2_req(alt2_req), .alt3_req(alt3_req), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .fn_in(fn_in),
        .timer_pwm_module_a_ext_clk(clk_a), .timer_pwm_module_b_ext_clk(clk_b),
        .sixteen_bit_modulo_timer_ext_clk(clk_m));
    spfm_pad_model spfm_pad_model_i (.pad_out(pad_out), .pad_oe(pad_oe),
        .ext_level(ext_level), .pad_in(pad_in));
    always #2 ref_clk = ~ref_clk;
    // ============================================================
    // Expectations
    function automatic int owner(input int i);
        if (alt3_req.en[i] === 1'b1) return 3;
        if (alt2_req.en[i] === 1'b1) return 2;
        if (alt1_req.en[i] === 1'b1) return 1;
        return 0;
    endfunction
    function automatic logic [59:0] exp_drive();
        logic [29:0] o, e;
        for (int i = 0; i < 30; i++)
        begin
            case (owner(i))
                3: {o[i], e[i]} = {alt3_req.out[i], alt3_req.oe[i]};
                2: {o[i], e[i]} = {alt2_req.out[i], alt2_req.oe[i]};
                1: {o[i], e[i]} = {alt1_req.out[i], alt1_req.oe[i]};
                default: {o[i], e[i]} = {port_req.out[i],
                    port_req.oe[i] | (i == spfm_pkg::PIN_OUT_ONLY)};
            endcase
        end
        e[spfm_pkg::PIN_IN_ONLY] = 1'b0;
        return {o, e};
    endfunction
    // ============================================================
    // Checks
    task automatic cmp(input string nm, input logic [29:0] e, input logic [29:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end
    // Drive one request set, then check the drive and the routed inputs
    task automatic step(input logic [29:0] e1, e2, e3);
        logic [59:0] d;
        logic [29:0] pad, s [4];
        @(posedge ref_clk);
        port_req <= {30'($urandom()), 30'($urandom())};
        alt1_req <= {e1, 30'($urandom()), 30'($urandom())};
        alt2_req <= {e2, 30'($urandom()), 30'($urandom())};
        alt3_req <= {e3, 30'($urandom()), 30'($urandom())};
        ext_level <= 30'($urandom());
        @(posedge ref_clk);
        #1;
        d = exp_drive();
        cmp("pad_oe", d[29:0], pad_oe);
        cmp("pad_out", d[59:30] & d[29:0], pad_out & d[29:0]);
        pad = (d[59:30] & d[29:0]) | (~d[29:0] & ext_level);
        for (int k = 0; k < 4; k++)
            s[k] = 30'h0000_0000;
        for (int i = 0; i < 30; i++)
            s[owner(i)][i] = pad[i];
        s[0][spfm_pkg::PIN_OUT_ONLY] = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        cmp("fn_port", s[0], fn_in.port);
        cmp("fn_alt1", s[1], fn_in.alt1);
        cmp("fn_alt2", s[2], fn_in.alt2);
        cmp("fn_alt3", s[3], fn_in.alt3);
        cmp("ext_clks", {27'h0, {3{s[2][spfm_pkg::TIMER_CLK_PIN]}}},
            {27'h0, clk_a, clk_b, clk_m});
    endtask
    // ============================================================
    // Main sequence
    initial
    begin
        void'($urandom(41974));
        repeat (20) @(posedge ref_clk);
        // Released on the edge; outputs keep reset values until the next one
        rst_n <= 1'b1;
        #1;
        cmp("reset_oe", 30'h0000_0000, pad_oe);
        cmp("reset_fn", 30'h0000_0000, fn_in.alt2);
        cmp("reset_clk", 30'h0000_0000, {27'h0, clk_a, clk_b, clk_m});
        // Corner cases: no alternates, every alternate, timer clock alone on pin 5
        step('0, '0, '0);
        step('1, '1, '1);
        step('0, 30'h0000_0020, '0);
        step('1, 30'h0000_0020, '0);
        for (int n = 0; n < 300; n++)
        begin
            // Every fourth new owner comes after sharers are dropped, as software should; flags ignored
            if (n % 4 == 0)
                step('0, '0, '0);
            step(30'($urandom()), 30'($urandom()), 30'($urandom()));
        end
        close_out();
    end
endmodule
